// ---- verif/tb.sv ----
// Self-checking bench for the event counter and pulse timer, driven over AXI4-Lite.
// Assumes the ect_top register map and codes from ect_pkg, and a 200 MHz clock.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic l3 = 1'b0;
  logic l4 = 1'b0;
  logic [8:0] ev = '0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  // Read answers are always accepted, so back-to-back reads never retoggle rready
  logic rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, cev, pfin, pact;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata, rd_v;
  logic [15:0] rnd = 16'hB5F3;
  int bad_count = 0;
  int n_compared = 0;
  int cyc_n = 0;
  int n_cev = 0;
  int n_pf = 0;
  int n, m, k;

  always #2.5 clk_in = ~clk_in;

  ect_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cap_begin_in(ev[0]), .cap_finish_in(ev[1]),
    .shut_open_in(ev[2]), .shut_close_in(ev[3]), .unload_begin_in(ev[4]),
    .unload_finish_in(ev[5]), .profile_in(ev[6]), .profile_ok_in(ev[7]), .sync_in(ev[8]),
    .io_line_three_in(l3), .io_line_four_in(l4), .count_terminal_event_out(cev),
    .pulse_finish_event_out(pfin), .pulse_active_out(pact), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Event pulses are one cycle wide, so they are counted at every rising edge
  always @(posedge clk_in) begin
    cyc_n <= cyc_n + 1;
    if (cev === 1'b1) n_cev <= n_cev + 1;
    if (pfin === 1'b1) n_pf <= n_pf + 1;
    if (cyc_n == 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  // Readies are sampled at the falling edge, where they equal what the next rising edge sees
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ra, rw;
    ra = 1'b0;
    rw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clk_in);
      ra = ra | awready;
      rw = rw | wready;
      @(posedge clk_in);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
    end while (!(ra & rw));
    bready <= 1'b1;
    do begin
      @(negedge clk_in);
      ra = bvalid;
      @(posedge clk_in);
    end while (!ra);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic ra, rv;
    ra = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk_in);
      ra = ra | arready;
      rv = rvalid;
      v = rdata;
      last_resp = rresp;
      @(posedge clk_in);
      if (ra) arvalid <= 1'b0;
    end while (!rv);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a, rd_v);
    chk(rd_v, e);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask

  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev[i] <= 1'b0;
    @(posedge clk_in);
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rchk(ect_pkg::CNT_TERM_OFS, ect_pkg::TERM_RESET);
    rchk(ect_pkg::CNT_CTRL_OFS, ect_pkg::CTRL_RESET);
    rd(12'h0FC, rd_v);
    chk({30'h0, last_resp}, 32'h2);
    $display("test reset done");
    wr(ect_pkg::CNT_CTRL_OFS, 32'h71);
    wr(ect_pkg::CNT_CMD_OFS, 32'h1);
    rnd = lfsr(rnd);
    n = 1 + int'(rnd[2:0]);
    repeat (n) pulse(6);
    rchk(ect_pkg::CNT_VALUE_OFS, 32'(n));
    wr(ect_pkg::CNT_CTRL_OFS, 32'h1);
    repeat (2) pulse(6);
    rchk(ect_pkg::CNT_VALUE_OFS, 32'(n));
    wr(ect_pkg::CNT_CTRL_OFS, 32'h71);
    wr(ect_pkg::CNT_CMD_OFS, 32'h1);
    rchk(ect_pkg::CNT_CAPT_OFS, 32'(n));
    pulse(6);
    rchk(ect_pkg::CNT_VALUE_OFS, 32'h1);
    $display("test counter command done");
    // Line three clears the count; the clear edge select decides which transition clears it
    for (m = 0; m < 3; m++) begin
      wr(ect_pkg::CNT_CTRL_OFS, 32'h0000A071 | (32'(m) << 20));
      wr(ect_pkg::CNT_CMD_OFS, 32'h1);
      repeat (2) pulse(6);
      l3 <= 1'b1;
      cyc(6);
      rchk(ect_pkg::CNT_VALUE_OFS, (m == 1) ? 32'h2 : 32'h0);
      l3 <= 1'b0;
      cyc(6);
      rchk(ect_pkg::CNT_VALUE_OFS, 32'h0);
      rchk(ect_pkg::CNT_CAPT_OFS, (m == 2) ? 32'h0 : 32'h2);
    end
    $display("test line clear done");
    wr(ect_pkg::CNT_CTRL_OFS, 32'h0);
    rnd = lfsr(rnd);
    k = 2 + int'(rnd[1:0]);
    wr(ect_pkg::CNT_TERM_OFS, 32'(k));
    // Begin and clear sources both on the counter end: runs at enable and reloads itself
    wr(ect_pkg::CNT_CTRL_OFS, 32'h0000DD71);
    m = n_cev;
    rnd = lfsr(rnd);
    n = 3 + int'(rnd[2:0]);
    repeat (n) pulse(6);
    cyc(2);
    chk(32'(n_cev - m), 32'(n / k));
    rchk(ect_pkg::CNT_VALUE_OFS, 32'(n % k));
    if (n >= k) rchk(ect_pkg::CNT_CAPT_OFS, 32'(k));
    $display("test reload done");
    wr(ect_pkg::PLS_LEN_OFS, 32'h2);
    wr(ect_pkg::PLS_CTRL_OFS, 32'h1);
    wr(ect_pkg::PLS_CMD_OFS, 32'h1);
    rchk(ect_pkg::PLS_STATE_OFS, 32'h0);
    m = n_pf;
    cyc(700);
    rchk(ect_pkg::PLS_VALUE_OFS, 32'h2);
    chk(32'(n_pf - m), 32'h1);
    // Disabled first, so no microsecond tick can advance the value before it is read
    wr(ect_pkg::PLS_CTRL_OFS, 32'h0);
    wr(ect_pkg::PLS_CMD_OFS, 32'h1);
    rchk(ect_pkg::PLS_VALUE_OFS, 32'h0);
    wr(ect_pkg::PLS_CTRL_OFS, 32'h0B01);
    rchk(ect_pkg::PLS_STATE_OFS, 32'h1);
    wr(ect_pkg::PLS_LEN_OFS, 32'h5);
    rchk(ect_pkg::PLS_LEN_OFS, 32'h2);
    l4 <= 1'b1;
    cyc(6);
    rchk(ect_pkg::PLS_STATE_OFS, 32'h2);
    chk({31'h0, pact}, 32'h1);
    cyc(700);
    rchk(ect_pkg::PLS_STATE_OFS, 32'h3);
    wr(ect_pkg::PLS_CTRL_OFS, 32'h0);
    wr(ect_pkg::PLS_CTRL_OFS, 32'h00040B01);
    l4 <= 1'b0;
    cyc(6);
    rchk(ect_pkg::PLS_STATE_OFS, 32'h2);
    wr(ect_pkg::PLS_CTRL_OFS, 32'h0);
    $display("test timer done");
    for (m = 0; m < 9; m++) begin
      wr(ect_pkg::PLS_CTRL_OFS, 32'h1 | (32'(m + 1) << 8));
      pulse(m);
      rchk(ect_pkg::PLS_STATE_OFS, 32'h2);
      wr(ect_pkg::PLS_CTRL_OFS, 32'h0);
    end
    // The counter still reloads every k steps, so k steps always cross its end once
    wr(ect_pkg::PLS_CTRL_OFS, 32'h0D01);
    repeat (k) pulse(6);
    rchk(ect_pkg::PLS_STATE_OFS, 32'h2);
    wr(ect_pkg::PLS_CTRL_OFS, 32'h0);
    $display("test timer sources done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- verilog/ect_evt_if.sv ----
// Interface carrying the synchronised event set from the event front end to the core.
// Assumes both ends share clk_in.
`default_nettype none
interface ect_evt_if;
  logic [13:1] pulse;
  logic io_line_three_lvl;
  logic io_line_four_lvl;
  logic io_line_three_rise;
  logic io_line_three_fall;
  logic io_line_four_rise;
  logic io_line_four_fall;
  modport src (output pulse, io_line_three_lvl, io_line_four_lvl, io_line_three_rise, io_line_three_fall, io_line_four_rise,
    io_line_four_fall);
  modport dst (input pulse, io_line_three_lvl, io_line_four_lvl, io_line_three_rise, io_line_three_fall, io_line_four_rise,
    io_line_four_fall);
endinterface
`default_nettype wire

// ---- verilog/ect_line_sync.sv ----
// Synchronises the two I/O lines and detects their edges on the synchronised level.
// Assumes lines are asynchronous to clk_in.
`default_nettype none
module ect_line_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] line_in,
  ect_evt_if.src evt
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] last_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
      last_r <= 2'h0;
    end else begin
      meta_r <= line_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign evt.io_line_three_lvl = sync_r[0];
  assign evt.io_line_four_lvl = sync_r[1];
  assign evt.io_line_three_rise = sync_r[0] & ~last_r[0];
  assign evt.io_line_three_fall = ~sync_r[0] & last_r[0];
  assign evt.io_line_four_rise = sync_r[1] & ~last_r[1];
  assign evt.io_line_four_fall = ~sync_r[1] & last_r[1];
endmodule
`default_nettype wire

// ---- verilog/ect_pkg.sv ----
// Package for the event counter and pulse timer: register map, field codes, timing.
// Assumes a 200 MHz device clock and an AXI4-Lite register bus with 32-bit data.
`default_nettype none
package ect_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned US_TICK_CYCLES = CLK_MHZ;
  localparam logic [7:0] US_TICK_LAST = 8'(US_TICK_CYCLES - 1);

  localparam logic [11:0] CNT_CTRL_OFS = 12'h000;
  localparam logic [11:0] CNT_TERM_OFS = 12'h004;
  localparam logic [11:0] CNT_VALUE_OFS = 12'h008;
  localparam logic [11:0] CNT_CAPT_OFS = 12'h00C;
  localparam logic [11:0] CNT_CMD_OFS = 12'h010;
  localparam logic [11:0] PLS_CTRL_OFS = 12'h020;
  localparam logic [11:0] PLS_LEN_OFS = 12'h024;
  localparam logic [11:0] PLS_VALUE_OFS = 12'h028;
  localparam logic [11:0] PLS_STATE_OFS = 12'h02C;
  localparam logic [11:0] PLS_CMD_OFS = 12'h030;

  // Source select codes; code 0 means "off" (command driven)
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_CAP_BEGIN = 4'h1;
  localparam logic [3:0] SRC_CAP_FINISH = 4'h2;
  localparam logic [3:0] SRC_SHUT_OPEN = 4'h3;
  localparam logic [3:0] SRC_SHUT_CLOSE = 4'h4;
  localparam logic [3:0] SRC_UNLOAD_BEGIN = 4'h5;
  localparam logic [3:0] SRC_UNLOAD_FINISH = 4'h6;
  localparam logic [3:0] SRC_PROFILE = 4'h7;
  localparam logic [3:0] SRC_PROFILE_OK = 4'h8;
  localparam logic [3:0] SRC_SYNC = 4'h9;
  localparam logic [3:0] SRC_IO_LINE_THREE = 4'hA;
  localparam logic [3:0] SRC_IO_LINE_FOUR = 4'hB;
  localparam logic [3:0] SRC_PULSE_END = 4'hC;
  localparam logic [3:0] SRC_COUNT_END = 4'hD;

  localparam logic [1:0] EDGE_LOW_TO_HIGH = 2'h0;
  localparam logic [1:0] EDGE_HIGH_TO_LOW = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Control field positions (same layout for both units)
  localparam int unsigned CTL_ENABLE_BIT = 0;
  localparam int unsigned CTL_STEP_SRC_LSB = 4;
  localparam int unsigned CTL_BEGIN_SRC_LSB = 8;
  localparam int unsigned CTL_CLEAR_SRC_LSB = 12;
  localparam int unsigned CTL_STEP_EDGE_LSB = 16;
  localparam int unsigned CTL_BEGIN_EDGE_LSB = 18;
  localparam int unsigned CTL_CLEAR_EDGE_LSB = 20;
  localparam int unsigned CMD_CLEAR_BIT = 0;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TERM_RESET = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    ECT_PS_IDLE,
    ECT_PS_WAITING,
    ECT_PS_RUNNING,
    ECT_PS_DONE
  } ect_pulse_state_e;

  typedef logic [3:0] ect_src_t;
endpackage
`default_nettype wire

// ---- verilog/ect_top.sv ----
// Event counter and single microsecond pulse timer with an AXI4-Lite register slave.
// Assumes sensor event inputs are one-cycle pulses synchronous to clk_in.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`default_nettype none
module ect_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cap_begin_in,
  input wire logic cap_finish_in,
  input wire logic shut_open_in,
  input wire logic shut_close_in,
  input wire logic unload_begin_in,
  input wire logic unload_finish_in,
  input wire logic profile_in,
  input wire logic profile_ok_in,
  input wire logic sync_in,
  input wire logic io_line_three_in,
  input wire logic io_line_four_in,
  output logic count_terminal_event_out,
  output logic pulse_finish_event_out,
  output logic pulse_active_out,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  ect_evt_if evt ();

  ect_line_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .line_in({io_line_four_in, io_line_three_in}),
    .evt(evt)
  );

  logic cnt_end_r;
  logic pls_end_r;
  assign evt.pulse = {cnt_end_r, pls_end_r, evt.io_line_four_lvl, evt.io_line_three_lvl, sync_in,
    profile_ok_in, profile_in, unload_finish_in, unload_begin_in, shut_close_in,
    shut_open_in, cap_finish_in, cap_begin_in};

  // One decoder serves every source select, except a counter begin on the counter end, which starts at once, and a pulse begin off, which takes the command
  function automatic logic src_fire(input ect_pkg::ect_src_t src, input logic [1:0] edge_sel,
    input logic [13:1] ev, input logic [3:0] ln);
    logic [1:0] e;
    e = 2'h0;
    if (src == ect_pkg::SRC_IO_LINE_THREE) begin
      e = ln[1:0];
    end else if (src == ect_pkg::SRC_IO_LINE_FOUR) begin
      e = ln[3:2];
    end
    if (src == ect_pkg::SRC_IO_LINE_THREE || src == ect_pkg::SRC_IO_LINE_FOUR) begin
      unique case (edge_sel)
        ect_pkg::EDGE_LOW_TO_HIGH: src_fire = e[0];
        ect_pkg::EDGE_HIGH_TO_LOW: src_fire = e[1];
        default: src_fire = e[0] | e[1];
      endcase
    end else if (src == ect_pkg::SRC_OFF || src > ect_pkg::SRC_COUNT_END) begin
      src_fire = 1'b0;
    end else begin
      src_fire = ev[src];
    end
  endfunction

  logic [3:0] lines;
  assign lines = {evt.io_line_four_fall, evt.io_line_four_rise, evt.io_line_three_fall, evt.io_line_three_rise};

  logic [31:0] cnt_ctrl_r;
  logic [31:0] cnt_term_r;
  logic [31:0] cnt_val_r;
  logic [31:0] cnt_capt_r;
  logic cnt_run_r;
  logic [31:0] pls_ctrl_r;
  logic [31:0] pls_len_r;
  logic [31:0] pls_val_r;
  logic [7:0] tick_r;
  ect_pkg::ect_pulse_state_e pls_state_r;

  logic cnt_cmd;
  logic pls_cmd;
  logic cfg_wr;
  logic [11:0] wr_addr;

  ect_pkg::ect_src_t cnt_step_src;
  ect_pkg::ect_src_t cnt_begin_src;
  ect_pkg::ect_src_t cnt_clear_src;
  ect_pkg::ect_src_t pls_begin_src;
  assign cnt_step_src = cnt_ctrl_r[ect_pkg::CTL_STEP_SRC_LSB +: 4];
  assign cnt_begin_src = cnt_ctrl_r[ect_pkg::CTL_BEGIN_SRC_LSB +: 4];
  assign cnt_clear_src = cnt_ctrl_r[ect_pkg::CTL_CLEAR_SRC_LSB +: 4];
  assign pls_begin_src = pls_ctrl_r[ect_pkg::CTL_BEGIN_SRC_LSB +: 4];

  logic cnt_step;
  logic cnt_begin;
  logic cnt_clear_src_hit;
  logic cnt_at_term;
  assign cnt_step = src_fire(cnt_step_src, cnt_ctrl_r[ect_pkg::CTL_STEP_EDGE_LSB +: 2],
    evt.pulse, lines);
  assign cnt_begin = src_fire(cnt_begin_src, cnt_ctrl_r[ect_pkg::CTL_BEGIN_EDGE_LSB +: 2],
    evt.pulse, lines);
  assign cnt_clear_src_hit = src_fire(cnt_clear_src,
    cnt_ctrl_r[ect_pkg::CTL_CLEAR_EDGE_LSB +: 2], evt.pulse, lines);
  assign cnt_at_term = cnt_run_r && cnt_step && (cnt_val_r + 32'h1 == cnt_term_r);

  // Counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_val_r <= 32'h0;
      cnt_capt_r <= 32'h0;
      cnt_run_r <= 1'b0;
      cnt_end_r <= 1'b0;
    end else begin
      cnt_end_r <= cnt_at_term;
      if (!cnt_ctrl_r[ect_pkg::CTL_ENABLE_BIT]) begin
        cnt_run_r <= 1'b0;
      end else if (cnt_cmd) begin
        cnt_capt_r <= cnt_val_r;
        cnt_val_r <= 32'h0;
        cnt_run_r <= 1'b1;
      end else if (cnt_clear_src_hit) begin
        cnt_capt_r <= cnt_val_r;
        cnt_val_r <= 32'h0;
        // Self-reload keeps running; other sources wait for a new begin
        cnt_run_r <= (cnt_clear_src == ect_pkg::SRC_COUNT_END);
      end else begin
        if (!cnt_run_r && (cnt_begin_src == ect_pkg::SRC_COUNT_END || cnt_begin)) begin
          cnt_run_r <= 1'b1;
        end
        if (cnt_run_r && cnt_step) begin
          cnt_val_r <= cnt_val_r + 32'h1;
        end
      end
    end
  end

  // Microsecond tick keeps running, so the first counted microsecond of a pulse can be cut short
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_r <= 8'h0;
    end else if (tick_r == ect_pkg::US_TICK_LAST) begin
      tick_r <= 8'h0;
    end else begin
      tick_r <= tick_r + 8'h1;
    end
  end
  logic us_tick;
  assign us_tick = (tick_r == ect_pkg::US_TICK_LAST);

  logic pls_on;
  logic pls_begin;
  logic pls_src_off;
  assign pls_on = pls_ctrl_r[ect_pkg::CTL_ENABLE_BIT];
  assign pls_src_off = (pls_begin_src == ect_pkg::SRC_OFF);
  assign pls_begin = pls_src_off ? pls_cmd : src_fire(pls_begin_src,
    pls_ctrl_r[ect_pkg::CTL_BEGIN_EDGE_LSB +: 2], evt.pulse, lines);

  // Pulse timer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pls_state_r <= ect_pkg::ECT_PS_IDLE;
      pls_val_r <= 32'h0;
      pls_end_r <= 1'b0;
    end else begin
      pls_end_r <= 1'b0;
      if (pls_cmd) begin
        pls_val_r <= 32'h0;
      end
      if (!pls_on) begin
        pls_state_r <= pls_src_off ? ect_pkg::ECT_PS_IDLE : ect_pkg::ECT_PS_WAITING;
      end else begin
        unique case (pls_state_r)
          ect_pkg::ECT_PS_IDLE,
          ect_pkg::ECT_PS_WAITING,
          ect_pkg::ECT_PS_DONE: begin
            if (pls_begin) begin
              pls_val_r <= 32'h0;
              pls_state_r <= ect_pkg::ECT_PS_RUNNING;
            end
          end
          ect_pkg::ECT_PS_RUNNING: begin
            if (!pls_cmd && us_tick) begin
              pls_val_r <= pls_val_r + 32'h1;
              if (pls_val_r + 32'h1 >= pls_len_r) begin
                pls_end_r <= 1'b1;
                pls_state_r <= ect_pkg::ECT_PS_DONE;
              end
            end
          end
        endcase
      end
    end
  end

  logic [1:0] pls_state_rd;
  always_comb begin
    if (pls_src_off) begin
      pls_state_rd = 2'(ect_pkg::ECT_PS_IDLE);
    end else if (pls_state_r == ect_pkg::ECT_PS_IDLE) begin
      pls_state_rd = 2'(ect_pkg::ECT_PS_WAITING);
    end else begin
      pls_state_rd = 2'(pls_state_r);
    end
  end

  assign count_terminal_event_out = cnt_end_r;
  assign pulse_finish_event_out = pls_end_r;
  assign pulse_active_out = (pls_state_r == ect_pkg::ECT_PS_RUNNING);

  // AXI4-Lite write side: address and data latched independently
  logic aw_r;
  logic w_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic bad_r;
  assign s_axi_awready_out = !aw_r && !bvalid_r;
  assign s_axi_wready_out = !w_r && !bvalid_r;
  assign wr_addr = awaddr_r;
  logic wr_go;
  assign wr_go = aw_r && w_r && !bvalid_r;
  logic wr_mapped;
  assign wr_mapped = wr_addr == ect_pkg::CNT_CTRL_OFS || wr_addr == ect_pkg::CNT_TERM_OFS ||
    wr_addr == ect_pkg::CNT_CMD_OFS || wr_addr == ect_pkg::PLS_CTRL_OFS ||
    wr_addr == ect_pkg::PLS_LEN_OFS || wr_addr == ect_pkg::PLS_CMD_OFS;
  assign cnt_cmd = wr_go && wr_addr == ect_pkg::CNT_CMD_OFS && wstrb_r[0] &&
    wdata_r[ect_pkg::CMD_CLEAR_BIT];
  assign pls_cmd = wr_go && wr_addr == ect_pkg::PLS_CMD_OFS && wstrb_r[0] &&
    wdata_r[ect_pkg::CMD_CLEAR_BIT];
  // Pulse settings accepted only while disabled, except the enable bit itself
  assign cfg_wr = wr_go && !pls_on;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 12'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr_in[11:2], 2'h0};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        bvalid_r <= 1'b1;
        bad_r <= !wr_mapped;
      end else if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bad_r ? 2'h2 : 2'h0;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ctrl_r <= ect_pkg::CTRL_RESET;
      cnt_term_r <= ect_pkg::TERM_RESET;
      pls_ctrl_r <= ect_pkg::CTRL_RESET;
      pls_len_r <= 32'h0;
    end else if (wr_go) begin
      if (wr_addr == ect_pkg::CNT_CTRL_OFS) begin
        cnt_ctrl_r <= merge(cnt_ctrl_r, wdata_r, wstrb_r);
      end
      if (wr_addr == ect_pkg::CNT_TERM_OFS) begin
        cnt_term_r <= merge(cnt_term_r, wdata_r, wstrb_r);
      end
      if (wr_addr == ect_pkg::PLS_CTRL_OFS) begin
        if (cfg_wr) begin
          pls_ctrl_r <= merge(pls_ctrl_r, wdata_r, wstrb_r);
        end else if (wstrb_r[0]) begin
          pls_ctrl_r[ect_pkg::CTL_ENABLE_BIT] <= wdata_r[ect_pkg::CTL_ENABLE_BIT];
        end
      end
      if (wr_addr == ect_pkg::PLS_LEN_OFS && cfg_wr) begin
        pls_len_r <= merge(pls_len_r, wdata_r, wstrb_r);
      end
    end
  end

  // AXI4-Lite read side: one-cycle registered answer
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic rbad_r;
  assign s_axi_arready_out = !rvalid_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rbad_r <= 1'b0;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_r <= 1'b1;
      rbad_r <= 1'b0;
      unique case ({s_axi_araddr_in[11:2], 2'h0})
        ect_pkg::CNT_CTRL_OFS: rdata_r <= cnt_ctrl_r;
        ect_pkg::CNT_TERM_OFS: rdata_r <= cnt_term_r;
        ect_pkg::CNT_VALUE_OFS: rdata_r <= cnt_val_r;
        ect_pkg::CNT_CAPT_OFS: rdata_r <= cnt_capt_r;
        ect_pkg::PLS_CTRL_OFS: rdata_r <= pls_ctrl_r;
        ect_pkg::PLS_LEN_OFS: rdata_r <= pls_len_r;
        ect_pkg::PLS_VALUE_OFS: rdata_r <= pls_val_r;
        ect_pkg::PLS_STATE_OFS: rdata_r <= {30'h0, pls_state_rd};
        ect_pkg::CNT_CMD_OFS,
        ect_pkg::PLS_CMD_OFS: rdata_r <= 32'h0;
        default: begin
          rdata_r <= 32'h0;
          rbad_r <= 1'b1;
        end
      endcase
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rbad_r ? 2'h2 : 2'h0;

  a_cnt_clear_capt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cnt_cmd && cnt_ctrl_r[0] |=> cnt_val_r == 32'h0 && cnt_capt_r == $past(cnt_val_r) && cnt_run_r)
    else $error("counter clear did not zero and capture");
  a_cnt_term_evt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cnt_end_r |-> $past(cnt_val_r) + 32'h1 == cnt_term_r)
    else $error("terminal event without reaching terminal value");
  a_cnt_off_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cnt_step_src == ect_pkg::SRC_OFF && !cnt_cmd && !cnt_clear_src_hit |=> $stable(cnt_val_r))
    else $error("counter moved with step source off");
  a_cnt_src_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cnt_ctrl_r[0] && !cnt_cmd && cnt_clear_src_hit && cnt_clear_src != ect_pkg::SRC_COUNT_END
    |=> !cnt_run_r)
    else $error("counter ran on after source clear");
  a_pls_cfg_lock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pls_on |=> $stable(pls_len_r))
    else $error("pulse length changed while enabled");
  a_pls_idle_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_axi_arvalid_in && s_axi_arready_out && pls_src_off &&
    s_axi_araddr_in[11:2] == ect_pkg::PLS_STATE_OFS[11:2] |=> s_axi_rdata_out == 32'h0)
    else $error("state not idle with start source off");
  a_pls_clear_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pls_cmd |=> pls_val_r == 32'h0)
    else $error("pulse clear did not zero value");
  a_pls_end_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pls_end_r |-> pls_state_r == ect_pkg::ECT_PS_DONE && pls_val_r >= pls_len_r)
    else $error("pulse end without full length");
  a_us_tick_rate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    us_tick |=> !us_tick [*8])
    else $error("microsecond tick too frequent");
  a_pls_cmd_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pls_on && pls_src_off && pls_cmd && pls_state_r != ect_pkg::ECT_PS_RUNNING
    |=> pls_state_r == ect_pkg::ECT_PS_RUNNING)
    else $error("clear command did not start timer");
endmodule
`default_nettype wire
